// ---- fspc_pkg.sv ----
package fspc_pkg;

   // Array geometry
   localparam int DATA_W = 32;
   localparam int CHK_W  = 6;
   localparam int BLK_W  = 3;
   localparam int WORD_W = 3;
   localparam int ADDR_W = BLK_W + WORD_W;
   localparam int BLK_N  = 1 << BLK_W;
   localparam int WPB    = 1 << WORD_W;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_ADDR   = 8'h08;
   localparam logic [7:0] OFS_WDATA  = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_SHIELD = 8'h14;
   localparam logic [7:0] OFS_NVINFO = 8'h18;

   // Field positions
   localparam int CTRL_SW_EN   = 0;
   localparam int CTRL_ENV     = 1;
   localparam int CTRL_BLOCK   = 2;
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_IMM      = 8;
   localparam int STATUS_REJ   = 8;
   localparam int SHIELD_LO    = 0;
   localparam int SHIELD_HI    = 8;
   localparam int NV_FLAG      = 0;
   localparam int NV_SWAP      = 1;
   localparam int NV_BPROT     = 2;
   localparam int NV_ALT_VALID = 3;
   localparam int NV_LOCK_LSB  = 8;
   localparam int NV_VALID_LSB = 16;

   // Status codes
   localparam logic [7:0] ST_SUCCESS   = 8'h00;
   localparam logic [7:0] ST_IDLE      = 8'h30;
   localparam logic [7:0] ST_RUNNING   = 8'hff;
   localparam logic [7:0] ST_ERR_PIN   = 8'h01;
   localparam logic [7:0] ST_ERR_PARAM = 8'h05;
   localparam logic [7:0] ST_ERR_PROT  = 8'h10;
   localparam logic [7:0] ST_ERR_FLOW  = 8'h1f;

   // Reset values and fixed contents
   localparam logic [BLK_W-1:0]  SHIELD_LO_RST = 3'h0;
   localparam logic [BLK_W-1:0]  SHIELD_HI_RST = 3'h7;
   localparam logic [BLK_W-1:0]  BOOT_BLK      = 3'h0;
   localparam logic [BLK_W-1:0]  ALT_BLK       = 3'h1;
   localparam logic [DATA_W-1:0] ERASED_WORD   = 32'hffff_ffff;
   localparam logic [31:0]       RAM_RSV_BYTES = 32'h0000_1000;

   // Timing
   localparam int CLK_MHZ  = 10;
   localparam int ERASE_NS = 20000;
   localparam int WRITE_NS = 10000;
   localparam int ERASE_CYC = (ERASE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC = (WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;

   typedef enum logic [2:0] {
      OP_NONE, OP_ERASE, OP_WRITE, OP_TEMP_SWAP,
      OP_SWAP_TOGGLE, OP_LOCK, OP_BOOT_PROT
   } fspc_op_e;

   typedef enum logic {S_IDLE, S_RUN} fspc_state_e;

   function automatic logic in_window(input logic [BLK_W-1:0] blk,
                                      input logic [BLK_W-1:0] lo,
                                      input logic [BLK_W-1:0] hi);
      return (blk >= lo) && (blk <= hi);
   endfunction

endpackage

// ---- fspc_ecc.sv ----
`timescale 1ns/1ns
module fspc_ecc
   import fspc_pkg::*;
(
   // Encoder
   input  wire logic [fspc_pkg::DATA_W-1:0] enc_data,
   output logic      [fspc_pkg::CHK_W-1:0]  enc_chk,
   // Decoder
   input  wire logic [fspc_pkg::DATA_W-1:0] dec_data,
   input  wire logic [fspc_pkg::CHK_W-1:0]  dec_chk,
   output logic      [fspc_pkg::DATA_W-1:0] cor_data,
   output logic                             cor_flag
);

   // Code position of data bit j, skipping the check-bit positions
   function automatic logic [CHK_W-1:0] pos_of(input int j);
      int p;
      if (j < 1) p = j + 3;
      else if (j < 4) p = j + 4;
      else if (j < 11) p = j + 5;
      else if (j < 26) p = j + 6;
      else p = j + 7;
      return CHK_W'(p);
   endfunction

   function automatic logic [CHK_W-1:0] chk_of(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      c = '0;
      for (int j = 0; j < DATA_W; j++) begin
         if (d[j]) c = c ^ pos_of(j);
      end
      return c;
   endfunction

   logic [CHK_W-1:0] syn;

   assign enc_chk = chk_of(enc_data);
   assign syn     = chk_of(dec_data) ^ dec_chk;
   assign cor_flag = (syn != '0);

   // Purely combinational, so a corrected read costs no extra cycle
   always_comb begin
      for (int j = 0; j < DATA_W; j++) begin
         cor_data[j] = dec_data[j] ^ (syn == pos_of(j));
      end
   end

endmodule

// ---- fspc_flash_array.sv ----
`timescale 1ns/1ns
module fspc_flash_array
   import fspc_pkg::*;
(
   // Clock
   input  wire logic                        core_clk,
   // Word program
   input  wire logic                        wr_en,
   input  wire logic [fspc_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [fspc_pkg::DATA_W-1:0] wr_data,
   input  wire logic [fspc_pkg::CHK_W-1:0]  wr_chk,
   // Block erase
   input  wire logic                        ers_en,
   input  wire logic [fspc_pkg::BLK_W-1:0]  ers_blk,
   input  wire logic [fspc_pkg::CHK_W-1:0]  ers_chk,
   // Read
   input  wire logic [fspc_pkg::ADDR_W-1:0] rd_addr,
   output logic      [fspc_pkg::DATA_W-1:0] rd_data,
   output logic      [fspc_pkg::CHK_W-1:0]  rd_chk
);

   // Cell contents are not cleared by reset, like real flash
   logic [DATA_W-1:0] data_mem [WPB*BLK_N];
   logic [CHK_W-1:0]  chk_mem  [WPB*BLK_N];

   always_ff @(posedge core_clk) begin
      if (ers_en) begin
         for (int w = 0; w < WPB; w++) begin
            data_mem[{ers_blk, WORD_W'(w)}] <= ERASED_WORD;
            chk_mem[{ers_blk, WORD_W'(w)}]  <= ers_chk;
         end
      end else if (wr_en) begin
         data_mem[wr_addr] <= wr_data;
         chk_mem[wr_addr]  <= wr_chk;
      end
   end

   assign rd_data = data_mem[rd_addr];
   assign rd_chk  = chk_mem[rd_addr];

endmodule

// ---- fspc_top.sv ----
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module fspc_top
   import fspc_pkg::*;
#(
   parameter logic [31:0] RAM_END = 32'h0000_ffff
)
(
   // Clock and resets
   input  wire logic                        core_clk,
   input  wire logic                        arst_n,
   input  wire logic                        pwr_on_rst_n,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Programming enable
   input  wire logic                        flash_mode_enable_pin,
   // Instruction fetch
   input  wire logic                        fetch_req,
   input  wire logic [fspc_pkg::ADDR_W-1:0] fetch_addr,
   output logic                             fetch_valid,
   output logic                             fetch_err,
   output logic      [fspc_pkg::DATA_W-1:0] fetch_data,
   output logic                             fetch_corrected,
   // System status
   output logic                             flash_busy,
   output logic                             ram_fw_claim,
   output logic      [31:0]                 ram_fw_base
);
   import fspc_pkg::*;

   fspc_state_e         st_reg;
   fspc_op_e            op_reg;
   fspc_op_e            cmd_op;
   logic [CNT_W-1:0]    cnt_reg;
   logic [ADDR_W-1:0]   op_addr_reg;
   logic [DATA_W-1:0]   op_data_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [DATA_W-1:0]   wdata_reg;
   logic                ctrl_sw_en_reg;
   logic                ctrl_env_reg;
   logic                ctrl_block_reg;
   logic [7:0]          status_reg;
   logic                rej_reg;
   logic [BLK_W-1:0]    shield_lo_reg;
   logic [BLK_W-1:0]    shield_hi_reg;
   logic                nv_flag_reg;
   logic                nv_bprot_reg;
   logic [BLK_N-1:0]    nv_lock_reg;
   logic [BLK_N-1:0]    nv_valid_reg;
   logic                swap_reg;
   logic                boot_done_reg;
   logic                blk_wait_reg;
   logic                apb_acc;
   logic                apb_wr;
   logic                cmd_wr;
   logic                accept_timed;
   logic                accept_now;
   logic                prog_allowed;
   logic                op_done;
   logic [7:0]          verdict;
   logic [BLK_W-1:0]    cmd_blk;
   logic                mem_we;
   logic                mem_ers;
   logic [CHK_W-1:0]    enc_chk;
   logic [DATA_W-1:0]   rd_data;
   logic [CHK_W-1:0]    rd_chk;
   logic [DATA_W-1:0]   cor_data;
   logic                cor_flag;
   logic [BLK_W-1:0]    fetch_blk;
   logic [ADDR_W-1:0]   rd_addr;

   // Destructive access barred for this block
   function automatic logic write_barred(input logic [BLK_W-1:0] blk);
      return !in_window(blk, shield_lo_reg, shield_hi_reg)
             || nv_lock_reg[blk]
             || (nv_bprot_reg && (blk == BOOT_BLK));
   endfunction

   // Bus decode
   assign apb_acc = psel && penable;
   assign apb_wr  = apb_acc && pwrite && pready;
   // Taken on the first access cycle only; a held blocking call does not repeat it
   assign cmd_wr  = apb_acc && pwrite && (paddr == OFS_CMD) && !blk_wait_reg;
   assign cmd_op  = fspc_op_e'(pwdata[CMD_OP_LSB +: 3]);
   assign cmd_blk = addr_reg[ADDR_W-1 -: BLK_W];
   assign prog_allowed = flash_mode_enable_pin || ctrl_sw_en_reg;
   assign op_done = (st_reg == S_RUN) && (cnt_reg == '0);

   // Command verdict
   always_comb begin
      verdict      = ST_SUCCESS;
      accept_timed = 1'b0;
      accept_now   = 1'b0;
      if (st_reg == S_RUN) begin
         verdict = ST_RUNNING;
      end else if (!ctrl_env_reg) begin
         verdict = ST_ERR_FLOW;
      end else if (!prog_allowed) begin
         verdict = ST_ERR_PIN;
      end else begin
         case (cmd_op)
            OP_ERASE, OP_WRITE: begin
               if (write_barred(cmd_blk)) begin
                  verdict = ST_ERR_PROT;
               end else begin
                  verdict      = ST_RUNNING;
                  accept_timed = 1'b1;
               end
            end
            OP_TEMP_SWAP, OP_SWAP_TOGGLE, OP_LOCK, OP_BOOT_PROT: begin
               accept_now = 1'b1;
            end
            default: verdict = ST_ERR_PARAM;
         endcase
      end
   end

   // Blocking mode stalls the bus until the operation is over
   assign pready = !(blk_wait_reg && (st_reg == S_RUN))
                   && !(cmd_wr && accept_timed && ctrl_block_reg);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) blk_wait_reg <= 1'b0;
      else if (cmd_wr && accept_timed && ctrl_block_reg) blk_wait_reg <= 1'b1;
      else if (apb_acc && pready) blk_wait_reg <= 1'b0;
   end

   assign pslverr = apb_acc && (paddr > OFS_NVINFO || paddr[1:0] != 2'h0);

   always_comb begin
      prdata = '0;
      case (paddr)
         OFS_CTRL: begin
            prdata[CTRL_SW_EN] = ctrl_sw_en_reg;
            prdata[CTRL_ENV]   = ctrl_env_reg;
            prdata[CTRL_BLOCK] = ctrl_block_reg;
         end
         OFS_CMD:    prdata[CMD_OP_LSB +: 3] = op_reg;
         OFS_ADDR:   prdata[ADDR_W-1:0] = addr_reg;
         OFS_WDATA:  prdata = wdata_reg;
         OFS_STATUS: begin
            prdata[7:0]        = status_reg;
            prdata[STATUS_REJ] = rej_reg;
         end
         OFS_SHIELD: begin
            prdata[SHIELD_LO +: BLK_W] = shield_lo_reg;
            prdata[SHIELD_HI +: BLK_W] = shield_hi_reg;
         end
         OFS_NVINFO: begin
            prdata[NV_FLAG]      = nv_flag_reg;
            prdata[NV_SWAP]      = swap_reg;
            prdata[NV_BPROT]     = nv_bprot_reg;
            prdata[NV_ALT_VALID] = nv_valid_reg[ALT_BLK];
            prdata[NV_LOCK_LSB +: BLK_N]  = nv_lock_reg;
            prdata[NV_VALID_LSB +: BLK_N] = nv_valid_reg;
         end
         default: prdata = '0;
      endcase
   end

   // Software registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_sw_en_reg <= 1'b0;
         ctrl_env_reg   <= 1'b0;
         ctrl_block_reg <= 1'b0;
      end else if (apb_wr && paddr == OFS_CTRL) begin
         ctrl_sw_en_reg <= pwdata[CTRL_SW_EN];
         ctrl_env_reg   <= pwdata[CTRL_ENV];
         ctrl_block_reg <= pwdata[CTRL_BLOCK];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else if (apb_wr && paddr == OFS_ADDR) begin
         addr_reg <= pwdata[ADDR_W-1:0];
      end else if (apb_wr && paddr == OFS_WDATA) begin
         wdata_reg <= pwdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         shield_lo_reg <= SHIELD_LO_RST;
         shield_hi_reg <= SHIELD_HI_RST;
      end else if (apb_wr && paddr == OFS_SHIELD) begin
         shield_lo_reg <= pwdata[SHIELD_LO +: BLK_W];
         shield_hi_reg <= pwdata[SHIELD_HI +: BLK_W];
      end
   end

   // Status: a rejection seen in the clearing cycle still sets the flag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) status_reg <= ST_IDLE;
      else if (op_done) status_reg <= ST_SUCCESS;
      else if (cmd_wr) status_reg <= verdict;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) rej_reg <= 1'b0;
      else if (cmd_wr && st_reg == S_RUN) rej_reg <= 1'b1;
      else if (apb_wr && paddr == OFS_STATUS && pwdata[STATUS_REJ])
         rej_reg <= 1'b0;
   end

   // Operation sequencer; operands are frozen so a refused command
   // cannot disturb the one in flight
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg      <= S_IDLE;
         op_reg      <= OP_NONE;
         cnt_reg     <= '0;
         op_addr_reg <= '0;
         op_data_reg <= '0;
      end else begin
         case (st_reg)
            S_IDLE: begin
               if (cmd_wr && (accept_timed || accept_now)) begin
                  op_reg <= cmd_op;
               end
               if (cmd_wr && accept_timed) begin
                  st_reg      <= S_RUN;
                  op_addr_reg <= addr_reg;
                  op_data_reg <= wdata_reg;
                  cnt_reg     <= (cmd_op == OP_ERASE) ?
                                 CNT_W'(ERASE_CYC - 1) :
                                 CNT_W'(WRITE_CYC - 1);
               end
            end
            S_RUN: begin
               if (op_done) st_reg <= S_IDLE;
               else cnt_reg <= cnt_reg - CNT_W'(1);
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   assign flash_busy = (st_reg == S_RUN);
   assign mem_we  = op_done && (op_reg == OP_WRITE);
   assign mem_ers = op_done && (op_reg == OP_ERASE);

   // Non-volatile extra area: only power-on clears it
   always_ff @(posedge core_clk or negedge pwr_on_rst_n) begin
      if (!pwr_on_rst_n) nv_lock_reg <= '0;
      else if (cmd_wr && accept_now && cmd_op == OP_LOCK)
         nv_lock_reg[cmd_blk] <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge pwr_on_rst_n) begin
      if (!pwr_on_rst_n) nv_bprot_reg <= 1'b0;
      else if (cmd_wr && accept_now && cmd_op == OP_BOOT_PROT)
         nv_bprot_reg <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge pwr_on_rst_n) begin
      if (!pwr_on_rst_n) nv_flag_reg <= 1'b0;
      else if (cmd_wr && accept_now && cmd_op == OP_SWAP_TOGGLE)
         nv_flag_reg <= !nv_flag_reg;
   end

   // A programmed alternate cluster stands for a valid boot image
   always_ff @(posedge core_clk or negedge pwr_on_rst_n) begin
      if (!pwr_on_rst_n) nv_valid_reg <= '0;
      else if (mem_ers) nv_valid_reg[op_addr_reg[ADDR_W-1 -: BLK_W]] <= 1'b0;
      else if (mem_we) nv_valid_reg[op_addr_reg[ADDR_W-1 -: BLK_W]] <= 1'b1;
   end

   // Active mapping: evaluated once after reset release
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) boot_done_reg <= 1'b0;
      else boot_done_reg <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) swap_reg <= 1'b0;
      else if (!boot_done_reg)
         swap_reg <= nv_flag_reg && nv_valid_reg[ALT_BLK];
      else if (cmd_wr && accept_now && cmd_op == OP_TEMP_SWAP)
         swap_reg <= !swap_reg;
      else if (cmd_wr && accept_now && cmd_op == OP_SWAP_TOGGLE
               && pwdata[CMD_IMM])
         swap_reg <= !swap_reg;
   end

   // Fetch path
   always_comb begin
      fetch_blk = fetch_addr[ADDR_W-1 -: BLK_W];
      if (swap_reg && fetch_blk == BOOT_BLK) fetch_blk = ALT_BLK;
      else if (swap_reg && fetch_blk == ALT_BLK) fetch_blk = BOOT_BLK;
   end
   assign rd_addr = {fetch_blk, fetch_addr[WORD_W-1:0]};

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_valid     <= 1'b0;
         fetch_err       <= 1'b0;
         fetch_data      <= '0;
         fetch_corrected <= 1'b0;
      end else begin
         fetch_valid     <= fetch_req && !ctrl_env_reg;
         fetch_err       <= fetch_req && ctrl_env_reg;
         fetch_data      <= ctrl_env_reg ? '0 : cor_data;
         fetch_corrected <= fetch_req && !ctrl_env_reg && cor_flag;
      end
   end

   // Firmware work area at the top of RAM
   assign ram_fw_claim = ctrl_env_reg;
   assign ram_fw_base  = RAM_END - RAM_RSV_BYTES + 32'h0000_0001;

   fspc_ecc u_ecc (
      .enc_data (mem_ers ? ERASED_WORD : op_data_reg),
      .enc_chk  (enc_chk),
      .dec_data (rd_data),
      .dec_chk  (rd_chk),
      .cor_data (cor_data),
      .cor_flag (cor_flag)
   );

   fspc_flash_array u_array (
      .core_clk (core_clk),
      .wr_en    (mem_we),
      .wr_addr  (op_addr_reg),
      .wr_data  (op_data_reg),
      .wr_chk   (enc_chk),
      .ers_en   (mem_ers),
      .ers_blk  (op_addr_reg[ADDR_W-1 -: BLK_W]),
      .ers_chk  (enc_chk),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .rd_chk   (rd_chk)
   );

   // Busy length counter keeps the duration check free of long repetition
   logic [CNT_W-1:0] busy_len_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) busy_len_reg <= '0;
      else busy_len_reg <= flash_busy ? busy_len_reg + CNT_W'(1) : '0;
   end

   // Checks
   localparam int AST_ERS = ERASE_CYC;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   AST_PIN_LOW: assert property (
      cmd_wr && st_reg == S_IDLE && ctrl_env_reg && !prog_allowed
      |=> status_reg == ST_ERR_PIN && !flash_busy)
      else $error("command taken with enable pin low");
   AST_RUN_STATUS: assert property (
      flash_busy |-> status_reg == ST_RUNNING)
      else $error("busy but status not running");
   AST_BUSY_REJECT: assert property (
      cmd_wr && flash_busy && !op_done
      |=> flash_busy && $stable(op_reg) && $stable(op_addr_reg) && rej_reg)
      else $error("busy command disturbed operation");
   AST_SHIELD: assert property (
      (mem_we || mem_ers) |->
      in_window(op_addr_reg[ADDR_W-1 -: BLK_W], shield_lo_reg, shield_hi_reg))
      else $error("reprogram outside shield window");
   AST_LOCKED: assert property (
      (mem_we || mem_ers) |-> !nv_lock_reg[op_addr_reg[ADDR_W-1 -: BLK_W]])
      else $error("locked block reprogrammed");
   AST_BOOT_PROT: assert property (
      (mem_we || mem_ers) && nv_bprot_reg
      |-> op_addr_reg[ADDR_W-1 -: BLK_W] != BOOT_BLK)
      else $error("protected boot cluster reprogrammed");
   AST_FETCH_BLOCKED: assert property (
      fetch_req && ctrl_env_reg |=> fetch_err && !fetch_valid)
      else $error("fetch served while environment active");
   AST_FETCH_LAT: assert property (
      fetch_req && !ctrl_env_reg
      |=> fetch_valid ##1 (fetch_valid == $past(fetch_req && !ctrl_env_reg)))
      else $error("fetch latency wrong");
   AST_ERASE_TIME: assert property (
      $fell(flash_busy) && op_reg == OP_ERASE
      |-> busy_len_reg == CNT_W'(AST_ERS) && status_reg == ST_SUCCESS)
      else $error("erase duration wrong");
   AST_BLOCK_HOLD: assert property (
      apb_acc && blk_wait_reg
      |-> pready == (!flash_busy && status_reg == ST_SUCCESS))
      else $error("blocking call released early");
   AST_TEMP_SWAP: assert property (
      cmd_wr && accept_now && cmd_op == OP_TEMP_SWAP && boot_done_reg
      |=> swap_reg != $past(swap_reg))
      else $error("temporary swap not applied");
   AST_STARTUP: assert property (
      !boot_done_reg && arst_n
      |=> swap_reg == $past(nv_flag_reg && nv_valid_reg[ALT_BLK]))
      else $error("start-up mapping wrong");

   COV_ERASE: cover property (mem_ers);
   COV_WRITE: cover property (mem_we);
   COV_REJECT: cover property (cmd_wr && flash_busy);
   COV_SWAP: cover property (cmd_wr && accept_now && cmd_op == OP_SWAP_TOGGLE);

endmodule

// ---- fspc_cpu_model.sv ----
`timescale 1ns/1ns
module fspc_cpu_model (
   // Bus
   input  wire logic        core_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // Enable pin
   output logic             flash_mode_enable_pin
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      flash_mode_enable_pin = 1'h0;
   end
   task automatic pin(input logic v);
      @(posedge core_clk);
      flash_mode_enable_pin <= v;
   endtask
   // Answer is taken at the rising edge that ends the access
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   import fspc_pkg::*;
   logic              core_clk = 1'h0, arst_n = 1'h0, pwr_on_rst_n = 1'h0;
   logic              psel, penable, pwrite, pready, pslverr;
   logic              flash_mode_enable_pin, fetch_valid, fetch_err;
   logic              fetch_corrected, flash_busy, ram_fw_claim;
   logic              fetch_req = 1'h0;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, ram_fw_base, r;
   logic [ADDR_W-1:0] fetch_addr = '0;
   logic [DATA_W-1:0] fetch_data;
   int                fails = 0, total_checks = 0, cyc = 0;
   always #50 core_clk = ~core_clk;
   // Ceiling well above the sum of all operation times
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done;
      end
   end
   fspc_cpu_model i_cpu (.core_clk, .pready, .prdata, .psel, .penable,
      .pwrite, .paddr, .pwdata, .flash_mode_enable_pin);
   fspc_top i_dut (.core_clk, .arst_n, .pwr_on_rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .flash_mode_enable_pin, .fetch_req, .fetch_addr, .fetch_valid,
      .fetch_err, .fetch_data, .fetch_corrected, .flash_busy,
      .ram_fw_claim, .ram_fw_base);
   task automatic chk(input string n, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_cpu.xfer(1'h1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a);
      i_cpu.xfer(1'h0, a, '0, r);
   endtask
   task automatic cmd(input logic [31:0] ctl, a, c);
      wr(OFS_CTRL, ctl);
      wr(OFS_ADDR, a);
      wr(OFS_CMD, c);
      rd(OFS_STATUS);
   endtask
   task automatic poll;
      for (int i = 0; i < 300 && r[7:0] === ST_RUNNING; i++) rd(OFS_STATUS);
   endtask
   // Outputs land on the edge after the request, read at its negedge
   task automatic fetch(input logic [5:0] a);
      @(posedge core_clk);
      fetch_req <= 1'h1;
      fetch_addr <= a;
      @(posedge core_clk);
      fetch_req <= 1'h0;
      @(negedge core_clk);
   endtask
   task automatic reset;
      arst_n <= 1'h0;
      repeat (12) @(posedge core_clk);
      arst_n <= 1'h1;
   endtask
   task automatic t_reset;
      rd(OFS_STATUS);
      chk("status", r[7:0], ST_IDLE);
      rd(OFS_SHIELD);
      chk("shield", r, 32'h0000_0700);
      chk("fw base", ram_fw_base, 32'h0000_f000);
      cmd(32'h2, 32'h10, 32'h1);
      chk("pin low", r[7:0], ST_ERR_PIN);
      chk("claim", ram_fw_claim, 32'h1);
   endtask
   task automatic t_bg;
      cmd(32'h3, 32'h10, 32'h1);
      chk("started", r[7:0], ST_RUNNING);
      chk("busy", flash_busy, 32'h1);
      fetch(6'h10);
      chk("no fetch", {fetch_valid, fetch_err}, 32'h1);
      wr(OFS_CMD, 32'h1);
      rd(OFS_STATUS);
      chk("busy cmd", r[8:0], 32'h1ff);
      poll;
      chk("erased", r[7:0], ST_SUCCESS);
      wr(OFS_STATUS, 32'h100);
      rd(OFS_STATUS);
      chk("rej clear", r[8], 32'h0);
   endtask
   task automatic t_write;
      i_cpu.pin(1'h1);
      wr(OFS_WDATA, 32'h1234_5678);
      cmd(32'h2, 32'h13, 32'h2);
      poll;
      wr(OFS_CTRL, 32'h0);
      fetch(6'h13);
      chk("word", fetch_data, 32'h1234_5678);
      chk("latency", {fetch_corrected, fetch_valid, fetch_err}, 32'h2);
      fetch(6'h12);
      chk("blank", fetch_data, ERASED_WORD);
   endtask
   task automatic t_block;
      int t0;
      wr(OFS_WDATA, 32'h0bad_f00d);
      t0 = cyc;
      cmd(32'h6, 32'h14, 32'h2);
      chk("held", 32'(cyc - t0 > WRITE_CYC), 32'h1);
      chk("done", r[7:0], ST_SUCCESS);
   endtask
   task automatic t_prot;
      logic [31:0] tb [5][3] = '{'{0, 6, 0}, '{0, 1, 8'h10},
         '{8'h18, 5, 0}, '{8'h18, 1, 8'h10}, '{8'h10, 0, 5}};
      wr(OFS_SHIELD, 32'h0000_0703);
      cmd(32'h2, 32'h10, 32'h1);
      chk("shield", r[7:0], ST_ERR_PROT);
      wr(OFS_SHIELD, 32'h0000_0700);
      foreach (tb[i]) begin
         cmd(32'h2, tb[i][0], tb[i][1]);
         chk("prot", r[7:0], tb[i][2]);
      end
   endtask
   task automatic t_swap;
      wr(OFS_WDATA, 32'h5a5a_a5a5);
      cmd(32'h2, 32'h08, 32'h2);
      poll;
      cmd(32'h2, 32'h0, 32'h4);
      rd(OFS_NVINFO);
      chk("flag", r[1:0], 32'h1);
      reset;
      rd(OFS_NVINFO);
      chk("boot map", r[1:0], 32'h3);
      fetch(6'h0);
      chk("alt word", fetch_data, 32'h5a5a_a5a5);
      cmd(32'h2, 32'h0, 32'h3);
      rd(OFS_NVINFO);
      chk("temp", r[1], 32'h0);
      reset;
      rd(OFS_NVINFO);
      chk("temp lost", r[1], 32'h1);
      cmd(32'h2, 32'h0, 32'h104);
      rd(OFS_NVINFO);
      chk("toggle now", r[1:0], 32'h0);
   endtask
   task automatic test_done;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1'h1;
      pwr_on_rst_n <= 1'h1;
      t_reset;
      t_bg;
      t_write;
      t_block;
      t_prot;
      t_swap;
      test_done;
   end
endmodule
